// >>> verilog/synth_latch_pkg.sv
package synth_latch_pkg;

    // ========
    // word format
    // ==========================================================
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_MAIN_CONFIG = 2'h0;
    localparam logic [1:0] SEL_REF_DIVIDER = 2'h1;
    localparam logic [1:0] SEL_FB_DIVIDER = 2'h2;
    localparam logic [1:0] SEL_FACTORY_TEST = 2'h3;

    // ========
    // latch layouts, bit 23 first
    // ==========================================================
    typedef struct packed {
        logic [1:0] prescaler_sel;
        logic [1:0] powerdown_mode;
        logic [2:0] pump_current_code_b;
        logic [2:0] pump_current_code_a;
        logic [1:0] output_level;
        logic output_mute_until_lock;
        logic pump_gain_sel;
        logic pump_three_state;
        logic detector_polarity;
        logic [2:0] monitor_select;
        logic divider_hold;
        logic [1:0] core_level;
        logic [1:0] latch_select;
    } main_config_t;

    typedef struct packed {
        logic halve_select;
        logic halve_output;
        logic pump_gain_sel;
        logic [12:0] main_count;
        logic reserved;
        logic [4:0] swallow_count;
        logic [1:0] latch_select;
    } fb_divider_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic [1:0] band_clk_div;
        logic factory_test_bit;
        logic lock_precision;
        logic [1:0] pulse_width;
        logic [13:0] ref_count;
        logic [1:0] latch_select;
    } ref_divider_t;

    // ========
    // values after reset
    // ==========================================================
    localparam logic [23:0] MAIN_CONFIG_RST = 24'h000000;
    localparam logic [23:0] FB_DIVIDER_RST = 24'h000000;
    localparam logic [23:0] REF_DIVIDER_RST = 24'h000000;
    localparam logic [23:0] FACTORY_TEST_RST = 24'h000000;

    // ========
    // monitor output sources
    // ==========================================================
    localparam logic [2:0] MON_OFF = 3'h0;
    localparam logic [2:0] MON_DIGITAL_LOCK = 3'h1;
    localparam logic [2:0] MON_FB_DIVIDER = 3'h2;
    localparam logic [2:0] MON_HIGH = 3'h3;
    localparam logic [2:0] MON_REF_DIVIDER = 3'h4;
    localparam logic [2:0] MON_ANALOG_LOCK = 3'h5;
    localparam logic [2:0] MON_SERIAL_DATA = 3'h6;
    localparam logic [2:0] MON_LOW = 3'h7;

    // ========
    // lock detection and band selection
    // ==========================================================
    localparam int LOCK_SET_NS = 15;
    localparam int LOCK_LOSE_NS = 25;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
    localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
    localparam logic [2:0] BAND_SEL_CYCLES = 3'h5;

endpackage : synth_latch_pkg

// >>> verilog/lock_detector.sv
`timescale 1ns/10ps
module lock_detector
#(
    parameter int ERR_W = 8
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_detector_tick,
    input wire logic [ERR_W-1:0] i_phase_err_ns,
    input wire logic i_lock_precision,
    output logic o_digital_lock
);

    // ========
    // consecutive good-cycle counter and sticky lock flag
    // ==========================================================
    logic [2:0] good_cnt_q;
    logic [2:0] good_cnt_d;
    logic lock_q;
    logic lock_d;
    logic [2:0] need;

    // next state per detector cycle
    always_comb
    begin
        good_cnt_d = good_cnt_q;
        lock_d = lock_q;
        need = i_lock_precision ? synth_latch_pkg::LOCK_CYCLES_FINE : synth_latch_pkg::LOCK_CYCLES_COARSE;
        if (i_detector_tick)
        begin
            if (lock_q)
            begin
                // hysteresis: only a large error drops lock
                if (i_phase_err_ns > ERR_W'(synth_latch_pkg::LOCK_LOSE_NS))  // R8
                begin
                    lock_d = 1'b0;
                    good_cnt_d = 3'h0;
                end
            end
            else if (i_phase_err_ns < ERR_W'(synth_latch_pkg::LOCK_SET_NS))
            begin
                if (good_cnt_q + 3'h1 >= need)  // R6 R7
                begin
                    lock_d = 1'b1;
                    good_cnt_d = 3'h0;
                end
                else
                begin
                    good_cnt_d = good_cnt_q + 3'h1;
                end
            end
            else
            begin
                good_cnt_d = 3'h0;  // R25
            end
        end
    end

    // register
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            good_cnt_q <= 3'h0;
            lock_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            good_cnt_q <= good_cnt_d;
            lock_q <= lock_d;
        end
    end

    assign o_digital_lock = lock_q;

endmodule : lock_detector

// >>> verilog/synth_serial_latch_control.sv
`timescale 1ns/10ps
// Overview of operation
// [R1] serial clock rise shifts data into a 24-bit register
// [R2] words arrive msb first; the two select bits land in bits 1:0
// [R3] load strobe rising edge copies the shift register into one latch
// [R4] select 00 main config, 01 reference divider, 10 feedback divider, 11 test
// [R5] the controller must not write the factory test latch
// [R6] precision clear: lock after three consecutive cycles under 15 ns
// [R7] precision set: lock after five consecutive cycles under 15 ns
// [R8] lock holds until a cycle shows error above 25 ns
// [R9] monitor output source chosen by the three-bit monitor select field
// [R10] antibacklash pulse width from the reference latch field
// [R11] band selection runs after power-up and on each feedback latch write
// [R12] controller writes reference, then main config, then feedback latch
// [R13] band selection lasts five cycles with tuning tied to the reference
// [R14] band select clock is the reference tick divided by 1, 2, 4 or 8
// [R15] controller keeps the band select clock at or below 1 MHz
// [R16] oscillator core current follows the two-bit core level field
// [R17] output tail current follows the two-bit output level field
// [R18] mute-until-lock keeps the output stage off until digital lock
// [R19] feedback latch field layout: swallow, main count, gain, halving bits
// [R20] reference latch field layout: count, precision, test bit, reserved
// [R21] main config latch field layout as listed
// [R22] halving bit in the feedback latch enables divide-by-two output
// [R23] chip enable low powers down and three-states the pump
// [R24] nothing reaches a latch without a load strobe rising edge
// [R25] before lock, a cycle at 15 ns or more restarts the count
module synth_serial_latch_control
#(
    parameter int ERR_W = 8
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_serial_clk,
    input wire logic i_serial_data,
    input wire logic i_load_strobe,
    input wire logic i_chip_enable,
    input wire logic i_ref_div_tick,
    input wire logic i_fb_div_tick,
    input wire logic i_detector_tick,
    input wire logic [ERR_W-1:0] i_phase_err_ns,
    output synth_latch_pkg::main_config_t o_main_config,
    output synth_latch_pkg::ref_divider_t o_ref_divider,
    output synth_latch_pkg::fb_divider_t o_fb_divider,
    output logic [23:0] o_test_latch,
    output logic o_monitor_output,
    output logic o_monitor_oe,
    output logic o_digital_lock,
    output logic o_tune_to_ref,
    output logic o_output_stage_on,
    output logic o_powered_down,
    output logic o_pump_three_state,
    output logic [1:0] o_core_level,
    output logic [1:0] o_output_level,
    output logic [1:0] o_pulse_width,
    output logic o_halve_output
);

    // ========
    // serial link: edge detection and shift register
    // ==========================================================
    logic sclk_prev_q;
    logic strobe_prev_q;
    logic [23:0] shift_q;
    logic [23:0] shift_d;
    logic sclk_rise;
    logic strobe_rise;

    // inputs are synchronous: edge from one stored copy
    always_comb
    begin
        sclk_rise = i_serial_clk & ~sclk_prev_q;
        strobe_rise = i_load_strobe & ~strobe_prev_q;
        shift_d = shift_q;
        if (sclk_rise)
        begin
            shift_d = {shift_q[22:0], i_serial_data};  // R1 R2
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            sclk_prev_q <= 1'b0;
            strobe_prev_q <= 1'b0;
            shift_q <= 24'h000000;
        end
        else if (i_clk_en)
        begin
            sclk_prev_q <= i_serial_clk;
            strobe_prev_q <= i_load_strobe;
            shift_q <= shift_d;
        end
    end

    // ========
    // latches
    // ==========================================================
    synth_latch_pkg::main_config_t main_q;
    synth_latch_pkg::main_config_t main_d;
    synth_latch_pkg::ref_divider_t ref_q;
    synth_latch_pkg::ref_divider_t ref_d;
    synth_latch_pkg::fb_divider_t fb_q;
    synth_latch_pkg::fb_divider_t fb_d;
    logic [23:0] test_q;
    logic [23:0] test_d;
    logic fb_write;

    // a load with a simultaneous shift commits the word before the new bit
    always_comb
    begin
        main_d = main_q;
        ref_d = ref_q;
        fb_d = fb_q;
        test_d = test_q;
        fb_write = 1'b0;
        if (strobe_rise)  // R3 R24
        begin
            case (shift_q[1:0])  // R4
                synth_latch_pkg::SEL_MAIN_CONFIG: main_d = shift_q;  // R21
                synth_latch_pkg::SEL_REF_DIVIDER: ref_d = shift_q;  // R20
                synth_latch_pkg::SEL_FB_DIVIDER:
                begin
                    fb_d = shift_q;  // R19
                    fb_write = 1'b1;
                end
                // stored only; its content steers nothing here (R5)
                default: test_d = shift_q;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            main_q <= synth_latch_pkg::MAIN_CONFIG_RST;
            ref_q <= synth_latch_pkg::REF_DIVIDER_RST;
            fb_q <= synth_latch_pkg::FB_DIVIDER_RST;
            test_q <= synth_latch_pkg::FACTORY_TEST_RST;
        end
        else if (i_clk_en)
        begin
            main_q <= main_d;
            ref_q <= ref_d;
            fb_q <= fb_d;
            test_q <= test_d;
        end
    end

    // ========
    // digital lock detection
    // ==========================================================
    logic lock;

    lock_detector #(
        .ERR_W(ERR_W)
    ) u_lock (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_detector_tick(i_detector_tick),
        .i_phase_err_ns(i_phase_err_ns),
        .i_lock_precision(ref_q.lock_precision),
        .o_digital_lock(lock)
    );

    // ========
    // band selection
    // ==========================================================
    typedef enum logic [0:0] {
        BAND_IDLE = 1'b0,
        BAND_RUN = 1'b1
    } band_state_t;

    band_state_t band_state_q;
    band_state_t band_state_d;
    logic band_pending_q;
    logic band_pending_d;
    logic [2:0] div_cnt_q;
    logic [2:0] div_cnt_d;
    logic [2:0] band_cnt_q;
    logic [2:0] band_cnt_d;
    logic band_tick;

    // divide ratio minus one
    function automatic logic [2:0] div_last(input logic [1:0] sel);
        div_last = 3'((4'h1 << sel) - 4'h1);
    endfunction : div_last

    // pending is set at reset so power-up runs a selection without a write;
    // a feedback write during a run restarts it from the first cycle
    always_comb
    begin
        band_state_d = band_state_q;
        band_pending_d = band_pending_q;
        div_cnt_d = div_cnt_q;
        band_cnt_d = band_cnt_q;
        band_tick = 1'b0;
        if (i_ref_div_tick)
        begin
            if (div_cnt_q >= div_last(ref_q.band_clk_div))  // R14
            begin
                div_cnt_d = 3'h0;
                band_tick = 1'b1;
            end
            else
            begin
                div_cnt_d = div_cnt_q + 3'h1;
            end
        end
        if (fb_write)
        begin
            band_pending_d = 1'b1;  // R11
        end
        case (band_state_q)
            BAND_IDLE:
            begin
                if (band_pending_q)
                begin
                    band_state_d = BAND_RUN;
                    band_pending_d = fb_write;
                    band_cnt_d = 3'h0;
                    div_cnt_d = 3'h0;
                end
            end
            BAND_RUN:
            begin
                if (band_pending_q)
                begin
                    band_pending_d = fb_write;
                    band_cnt_d = 3'h0;
                    div_cnt_d = 3'h0;
                end
                else if (band_tick)
                begin
                    if (band_cnt_q == synth_latch_pkg::BAND_SEL_CYCLES - 3'h1)  // R13
                    begin
                        band_state_d = BAND_IDLE;
                    end
                    band_cnt_d = band_cnt_q + 3'h1;
                end
            end
            default: band_state_d = BAND_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            band_state_q <= BAND_IDLE;
            band_pending_q <= 1'b1;
            div_cnt_q <= 3'h0;
            band_cnt_q <= 3'h0;
        end
        else if (i_clk_en)
        begin
            band_state_q <= band_state_d;
            band_pending_q <= band_pending_d;
            div_cnt_q <= div_cnt_d;
            band_cnt_q <= band_cnt_d;
        end
    end

    // ========
    // monitor selection and output controls
    // ==========================================================
    logic mon_out_d;
    logic mon_oe_d;
    logic powered_down_d;
    logic stage_on_d;
    logic pump_3state_d;
    logic mon_out_q;
    logic mon_oe_q;
    logic powered_down_q;
    logic stage_on_q;
    logic pump_3state_q;
    logic tune_q;

    // analog lock is open drain: pulled low on cycles with a real error
    always_comb
    begin
        mon_out_d = 1'b0;
        mon_oe_d = 1'b1;
        case (main_q.monitor_select)  // R9
            synth_latch_pkg::MON_OFF: mon_oe_d = 1'b0;
            synth_latch_pkg::MON_DIGITAL_LOCK: mon_out_d = lock;
            synth_latch_pkg::MON_FB_DIVIDER: mon_out_d = i_fb_div_tick;
            synth_latch_pkg::MON_HIGH: mon_out_d = 1'b1;
            synth_latch_pkg::MON_REF_DIVIDER: mon_out_d = i_ref_div_tick;
            synth_latch_pkg::MON_ANALOG_LOCK:
                mon_oe_d = i_detector_tick & (i_phase_err_ns >= ERR_W'(synth_latch_pkg::LOCK_SET_NS));
            synth_latch_pkg::MON_SERIAL_DATA: mon_out_d = shift_q[23];
            default: mon_out_d = 1'b0;
        endcase
        // soft power-down modes are the combinations with the lower mode bit set
        powered_down_d = ~i_chip_enable | main_q.powerdown_mode[0];  // R23
        pump_3state_d = powered_down_d | main_q.pump_three_state;  // R23
        stage_on_d = ~powered_down_d & (~main_q.output_mute_until_lock | lock);  // R18
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            mon_out_q <= 1'b0;
            mon_oe_q <= 1'b0;
            powered_down_q <= 1'b1;
            stage_on_q <= 1'b0;
            pump_3state_q <= 1'b1;
            tune_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            mon_out_q <= mon_out_d;
            mon_oe_q <= mon_oe_d;
            powered_down_q <= powered_down_d;
            stage_on_q <= stage_on_d;
            pump_3state_q <= pump_3state_d;
            tune_q <= (band_state_d == BAND_RUN);  // R13
        end
    end

    // all outputs come from flip-flops
    assign o_main_config = main_q;
    assign o_ref_divider = ref_q;
    assign o_fb_divider = fb_q;
    assign o_test_latch = test_q;
    assign o_monitor_output = mon_out_q;
    assign o_monitor_oe = mon_oe_q;
    assign o_digital_lock = lock;
    assign o_tune_to_ref = tune_q;
    assign o_output_stage_on = stage_on_q;
    assign o_powered_down = powered_down_q;
    assign o_pump_three_state = pump_3state_q;
    assign o_core_level = main_q.core_level;  // R16
    assign o_output_level = main_q.output_level;  // R17
    assign o_pulse_width = ref_q.pulse_width;  // R10
    assign o_halve_output = fb_q.halve_output;  // R22

endmodule : synth_serial_latch_control

// >>> tb/synth_latch_sva.sv
`timescale 1ns/10ps
module synth_latch_sva
#(
    parameter int ERR_W = 8
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_load_strobe,
    input wire logic i_chip_enable,
    input wire logic i_ref_div_tick,
    input wire logic i_detector_tick,
    input wire logic [ERR_W-1:0] i_phase_err_ns,
    input wire synth_latch_pkg::main_config_t o_main_config,
    input wire synth_latch_pkg::ref_divider_t o_ref_divider,
    input wire synth_latch_pkg::fb_divider_t o_fb_divider,
    input wire logic [23:0] o_test_latch,
    input wire logic o_monitor_oe,
    input wire logic o_digital_lock,
    input wire logic o_tune_to_ref,
    input wire logic o_output_stage_on,
    input wire logic o_powered_down,
    input wire logic o_pump_three_state
);
    // ========
    // clocking
    // ========
    // single clock domain
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // ========
    // latches
    // ========
    // latches move only on a strobe rise
    a_latch_hold: assert property (
        !($rose(i_load_strobe) && i_clk_en) |=> $stable(o_main_config) && $stable(o_ref_divider)
            && $stable(o_fb_divider) && $stable(o_test_latch))
        else $error("latch changed without a load strobe rise");

    // ========
    // lock detection
    // ========
    // lock rises only on a clean tick
    a_lock_rise: assert property (
        $rose(o_digital_lock) |-> $past(i_detector_tick) && ($past(i_phase_err_ns) < 15))
        else $error("lock rose without a clean detector cycle");
    a_lock_hold: assert property (
        o_digital_lock && i_clk_en && i_chip_enable && !(i_detector_tick && (i_phase_err_ns > 25))
            |=> o_digital_lock)
        else $error("lock dropped without a large error");
    a_lock_drop: assert property (
        o_digital_lock && i_clk_en && i_detector_tick && (i_phase_err_ns > 25) |=> !o_digital_lock)
        else $error("lock held through a large error");

    // ========
    // outputs
    // ========
    // past terms cover the one-cycle register lag
    a_mute_stage: assert property (
        o_main_config.output_mute_until_lock && !o_digital_lock && $past(o_main_config.output_mute_until_lock)
            && !$past(o_digital_lock) |-> !o_output_stage_on)
        else $error("output stage on while muted and unlocked");
    a_chip_off: assert property (
        !i_chip_enable |=> o_powered_down && o_pump_three_state)
        else $error("chip enable low did not power down");
    a_monitor_off: assert property (
        o_main_config.monitor_select == synth_latch_pkg::MON_OFF |=> !o_monitor_oe)
        else $error("monitor driven while off");

    // ========
    // band selection
    // ========
    // band select ends only on a reference tick
    a_band_end: assert property (
        $fell(o_tune_to_ref) |-> $past(i_ref_div_tick))
        else $error("band select ended without a reference tick");
    a_band_start: assert property (
        $changed(o_fb_divider) |=> o_tune_to_ref)
        else $error("feedback write did not start band select");

    // main scenarios reached
    c_lock: cover property ($rose(o_digital_lock));
    c_band: cover property ($fell(o_tune_to_ref));
    c_power: cover property ($rose(o_powered_down));
endmodule : synth_latch_sva

// >>> tb/serial_host_model.sv
`timescale 1ns/10ps
module serial_host_model
(
    input wire logic i_clk_sys,
    output logic o_serial_clk,
    output logic o_serial_data,
    output logic o_load_strobe
);
    // serial clock stands low outside frames
    initial
    begin
        o_serial_clk = 1'b0;
        o_serial_data = 1'b0;
        o_load_strobe = 1'b0;
    end

    // ========
    // word transfer
    // ========
    // one system cycle per clock phase
    task send(input logic [23:0] w, input logic commit);
        if (w[1:0] === 2'h3)
            return;
        for (int i = 23; i >= 0; i--)
        begin
            @(negedge i_clk_sys);
            o_serial_clk = 1'b0;
            o_serial_data = w[i];
            @(negedge i_clk_sys);
            o_serial_clk = 1'b1;
        end
        @(negedge i_clk_sys);
        o_serial_clk = 1'b0;
        o_serial_data = ~w[0]; // data released after the frame
        @(negedge i_clk_sys);
        o_load_strobe = commit;
        @(negedge i_clk_sys);
        o_load_strobe = 1'b0;
    endtask : send
endmodule : serial_host_model

// >>> tb/synth_serial_latch_control_tb_top.sv
`timescale 1ns/10ps
module synth_serial_latch_control_tb_top;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_chip_enable = 1'b1;
    logic i_ref_div_tick = 1'b0;
    logic i_detector_tick = 1'b0;
    logic [7:0] i_phase_err_ns = 8'h00;
    logic i_serial_clk, i_serial_data, i_load_strobe;
    synth_latch_pkg::main_config_t o_main_config;
    synth_latch_pkg::ref_divider_t o_ref_divider;
    synth_latch_pkg::fb_divider_t o_fb_divider;
    logic [23:0] o_test_latch;
    logic o_monitor_output, o_monitor_oe, o_digital_lock, o_tune_to_ref;
    logic o_output_stage_on, o_powered_down, o_pump_three_state, o_halve_output;
    logic [1:0] o_core_level, o_output_level, o_pulse_width;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    // ========
    // clock, parts
    // ========
    initial
    begin
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    // enable and feedback tick held constant
    synth_serial_latch_control dut_u (.i_clk_sys, .i_sys_rst, .i_clk_en(1'b1), .i_serial_clk, .i_serial_data,
        .i_load_strobe, .i_chip_enable, .i_ref_div_tick, .i_fb_div_tick(1'b0), .i_detector_tick, .i_phase_err_ns,
        .o_main_config, .o_ref_divider, .o_fb_divider, .o_test_latch, .o_monitor_output, .o_monitor_oe,
        .o_digital_lock, .o_tune_to_ref, .o_output_stage_on, .o_powered_down, .o_pump_three_state,
        .o_core_level, .o_output_level, .o_pulse_width, .o_halve_output);
    serial_host_model host_u (.i_clk_sys, .o_serial_clk(i_serial_clk), .o_serial_data(i_serial_data),
        .o_load_strobe(i_load_strobe));

    // ========
    // helpers
    // ========
    task check_val(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check_val

    task settle(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : settle

    // error scrambled after the tick
    task tick(input logic [7:0] err);
        @(negedge i_clk_sys);
        i_detector_tick = 1'b1;
        i_phase_err_ns = err;
        @(negedge i_clk_sys);
        i_detector_tick = 1'b0;
        i_phase_err_ns = ~err;
    endtask : tick

    task ref_tick;
        @(negedge i_clk_sys);
        i_ref_div_tick = 1'b1;
        @(negedge i_clk_sys);
        i_ref_div_tick = 1'b0;
    endtask : ref_tick

    // core 3, output level 1, mute on, chosen monitor source
    function automatic logic [23:0] main_word(input logic [2:0] mon);
        return 24'h00180c | {16'h0000, mon, 5'h00};
    endfunction : main_word

    // ========
    // scenarios
    // ========
    task t_powerup;
        repeat (2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        check_val(o_main_config | o_ref_divider | o_fb_divider | o_test_latch, 24'h000000);
        check_val({o_digital_lock, o_powered_down, o_pump_three_state}, 3'h3);
        i_sys_rst = 1'b0;
        for (int i = 1; i <= 5; i++)
        begin
            ref_tick;
            check_val(o_tune_to_ref, i < 5);
        end
    endtask : t_powerup

    task t_program;
        host_u.send(24'h120015, 1'b1);
        host_u.send(main_word(synth_latch_pkg::MON_HIGH), 1'b1);
        host_u.send(24'h40641e, 1'b1);
        settle(1);
        check_val(o_ref_divider, 24'h120015);
        check_val(o_main_config, 24'h00186c);
        check_val(o_fb_divider, 24'h40641e);
        check_val(o_test_latch, 24'h000000);
        check_val({o_pulse_width, o_core_level, o_output_level}, 6'h2d);
        check_val({o_halve_output, o_tune_to_ref, o_monitor_output}, 3'h7);
        check_val({o_powered_down, o_output_stage_on}, 2'h0);
    endtask : t_program

    task t_no_strobe;
        host_u.send(24'h3ffffd, 1'b0);
        settle(2);
        check_val(o_ref_divider, 24'h120015);
    endtask : t_no_strobe

    // divide by two: five band ticks need ten reference ticks
    task t_band;
        for (int i = 1; i <= 10; i++)
        begin
            ref_tick;
            check_val(o_tune_to_ref, i < 10);
        end
    endtask : t_band

    // 15 ns is not below the limit: count restarts
    task t_lock_coarse;
        logic [7:0] errs [5] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h00};
        foreach (errs[i])
        begin
            tick(errs[i]);
            check_val({o_digital_lock, o_output_stage_on}, 2'h0);
        end
        tick(8'h00);
        check_val(o_digital_lock, 1'b1);
        settle(1);
        check_val(o_output_stage_on, 1'b1);
    endtask : t_lock_coarse

    task t_lock_hold;
        tick(8'h19);
        check_val(o_digital_lock, 1'b1);
        tick(8'h1a);
        check_val(o_digital_lock, 1'b0);
    endtask : t_lock_hold

    task t_lock_fine;
        host_u.send(24'h160015, 1'b1);
        for (int i = 1; i <= 5; i++)
        begin
            tick(8'h0e);
            check_val(o_digital_lock, i == 5);
        end
        tick(8'hff);
        check_val(o_digital_lock, 1'b0);
    endtask : t_lock_fine

    task t_monitor;
        logic [2:0] mons [4] = '{synth_latch_pkg::MON_OFF, synth_latch_pkg::MON_HIGH,
            synth_latch_pkg::MON_LOW, synth_latch_pkg::MON_DIGITAL_LOCK};
        foreach (mons[i])
        begin
            host_u.send(main_word(mons[i]), 1'b1);
            settle(2);
            check_val({o_monitor_oe, o_monitor_output}, {i != 0, i == 1});
        end
    endtask : t_monitor

    task t_power;
        @(negedge i_clk_sys);
        i_chip_enable = 1'b0;
        settle(1);
        check_val({o_powered_down, o_pump_three_state}, 2'h3);
        i_chip_enable = 1'b1;
        settle(2);
        check_val({o_powered_down, o_pump_three_state}, 2'h0);
    endtask : t_power

    // ========
    // run control
    // ========
    task close_out;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // ceiling far above the run length
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            $display("[ERR] %0t run did not finish", $time);
            close_out;
        end
    end

    initial
    begin
        t_powerup;
        t_program;
        t_no_strobe;
        t_band;
        t_lock_coarse;
        t_lock_hold;
        t_lock_fine;
        t_monitor;
        t_power;
        close_out;
    end
endmodule : synth_serial_latch_control_tb_top

bind synth_serial_latch_control synth_latch_sva #(.ERR_W(ERR_W)) sva_u (.i_clk_sys, .i_sys_rst, .i_clk_en,
    .i_load_strobe, .i_chip_enable, .i_ref_div_tick, .i_detector_tick, .i_phase_err_ns, .o_main_config,
    .o_ref_divider, .o_fb_divider, .o_test_latch, .o_monitor_oe, .o_digital_lock, .o_tune_to_ref,
    .o_output_stage_on, .o_powered_down, .o_pump_three_state);
